// [design/pwm_deadtime_pair.sv]
// Deadtime generator and two-stage output path for one channel pair.
`timescale 1ns/1ns
module pwm_deadtime_pair #(
    parameter int DT_W = 12
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            tick_i,
    input  wire logic            comp_i,
    input  wire logic            top_i,
    input  wire logic            bot_i,
    input  wire logic [DT_W-1:0] dt_len_i,
    output logic                 top_o,
    output logic                 bot_o,
    output logic                 dead_o
);
    typedef struct packed {
        logic            a;
        logic            b;
        logic            prev;
        logic [DT_W-1:0] cnt;
        logic            top;
        logic            bot;
        logic            dead;
    } dt_state_t;

    dt_state_t s;
    dt_state_t next_s;

    // First stage samples the waveform, second stage drives the pads.
    always_comb begin
        next_s = s;
        next_s.a = top_i;
        next_s.b = bot_i;
        next_s.prev = s.a;
        if (!comp_i) begin
            next_s.cnt = '0;
        end else if (s.a != s.prev) begin
            next_s.cnt = dt_len_i;
        end else if (tick_i && s.cnt != '0) begin
            next_s.cnt = s.cnt - 1'b1;
        end
        if (comp_i) begin
            next_s.top = s.a && next_s.cnt == '0;
            next_s.bot = !s.a && next_s.cnt == '0;
        end else begin
            next_s.top = s.a;
            next_s.bot = s.b;
        end
        next_s.dead = comp_i && next_s.cnt != '0;
    end

    // State register; both pads inactive after reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign top_o  = s.top;
    assign bot_o  = s.bot;
    assign dead_o = s.dead;
endmodule

// [design/pwm_pair_deadtime_correction.sv]
// Six-channel PWM output stage with deadtime and top/bottom correction.
// How it works
// - Each pulse value is a signed 16-bit width in PWM clock periods.
// - Zero or negative value keeps the output inactive all period.
// - Value at or above the modulus keeps the output active all period.
// - Values 0000..7FFF used as is; 8000..FFFF replaced by zero.
// - Center-aligned pulse lasts twice the value.
// - Edge-aligned pulse lasts exactly the value.
// - Independent bit one: both pair outputs run from their own values.
// - Independent bit zero: the pair runs as complementary top/bottom.
// - In complementary mode bottom is the inverse of top, never both on.
// - Each generator input change inserts the programmed deadtime first.
// - During deadtime both outputs of the pair are inactive.
// - Deadtime path adds two bus clock cycles of latency.
// - A complementary pair takes its width from its odd or even value.
// - Method 00 means no correction, 01 means manual selection.
// - Method 10 samples the sense pins during deadtime.
// - Method 11 samples at half cycle (center) or cycle end (edge).
// - Channels 0, 2, 4 are top outputs; 1, 3, 5 are bottom outputs.
// - Deadtime is the count in PWM clock ticks, at most the prescaler divisor times the count.
// - Counter counts up/down when center-aligned, up when edge-aligned.
// - Manual bit 0 selects the even value, 1 the odd, from next cycle.
//
// Register words, byte addressed, one word every four bytes:
// 0x00 to 0x14 hold the six pulse values, channel c at four times c.
// 0x18 is the control word, 0x1c the period modulus, 0x20 the deadtime count.
// 0x24 is a read-only status word; writes to it are acknowledged and dropped.
// Every other address is acknowledged, reads zero and ignores writes.
// Values from 0x8000 upward count as underflow and act as zero.
//
// Control word fields:
// Bit 0 enables the generator; while it is low the counter rests at zero.
// Bit 1 selects edge-aligned periods; low selects center-aligned periods.
// Bits 3:2 pick the prescaler divisor as one, two, four or eight.
// Bits 5:4 pick the correction method for the complementary pairs.
// Bits 8:6 make pair p independent when bit 6+p is high.
// Bits 11:9 hold the manual odd/even choice, bit 9+p for pair p.
//
// Status word fields:
// Bits 14:0 show the period counter and bit 15 shows that it counts up.
// Bits 18:16 show which pairs currently use their odd value.
// Bits 21:19 show the latest current-sense samples.
// Bits 24:22 show which pairs are inside a deadtime interval.
//
// Timing:
// The bus answers every request with a one-cycle ack in the next cycle.
// Back-to-back requests are answered on every second cycle while stb is held.
// Read data stand only while ack is high and read zero otherwise.
// The waveform of each channel is computed from the counter every clock.
// It passes one register in this module and two in the pair module.
// A pad therefore follows a counter step after three clocks, of which two
// belong to the deadtime path.
// Mode, prescaler and modulus changes act at once, with no reload buffer.
// Software should stop the generator before it shrinks the modulus, since
// a counter already past the new end runs on to its full range first.
//
// Correction:
// Method 00 selects the even value of a complementary pair at each period end.
// Method 01 takes the manual bits at each period end.
// Methods 10 and 11 take the sampled sense pins at each period end.
// Method 10 follows the synchronised pin throughout each deadtime and keeps the last value.
// The sense pins pass two flip-flops before any sampling logic reads them.
// While the generator is stopped the automatic methods point at the odd values,
// so that the first period after enabling uses the odd registers.
// Deadtime is counted in PWM clock ticks from the change of the top waveform.
// While the generator is stopped every pair runs as independent, so all six
// pads rest low instead of the bottom pads showing the inverse of an idle top.
`timescale 1ns/1ns
module pwm_pair_deadtime_correction #(
    parameter int CNT_W = pwm_pkg::CNT_W,
    parameter int DT_W  = pwm_pkg::DT_W
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_we_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic [pwm_pkg::NPAIR-1:0]  current_sense_pin_i,
    output logic [pwm_pkg::NCH-1:0]         pwm_o
);
    import pwm_pkg::*;

    // The pulse values must fit the counter width and the deadtime field.
    if (CNT_W != VAL_W - 1 || DT_W < 1 || DT_W > 16) begin : g_bad_param
        $error("pwm stage: unsupported counter or deadtime width");
    end

    typedef struct packed {
        // Bus answer and read data registers.
        logic                       ack;
        logic [31:0]                rdat;
        // Software-visible registers and the prescaler count.
        logic [NCH-1:0][VAL_W-1:0]  val;
        logic                       en;
        logic                       edge_al;
        logic [1:0]                 prsc;
        corr_t                      corr;
        logic [NPAIR-1:0]           indep;
        logic [NPAIR-1:0]           ipol;
        logic [CNT_W-1:0]           mdl;
        logic [DT_W-1:0]            dtm;
        logic [DIV_W-1:0]           div;
        // Period counter and its direction.
        logic [CNT_W-1:0]           cnt;
        logic                       up;
        // Odd/even choice, sense samples and the pin synchroniser.
        logic [NPAIR-1:0]           sel;
        logic [NPAIR-1:0]           samp;
        logic [NPAIR-1:0]           sync1;
        logic [NPAIR-1:0]           sync2;
        // Channel waveforms ahead of the deadtime path.
        logic [NCH-1:0]             gen;
    } state_t;

    state_t           s;
    state_t           next_s;
    logic             tick;
    logic [NPAIR-1:0] dead;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Negative values underflow to zero; others pass unchanged.
    function automatic logic [CNT_W-1:0] clamp(input logic [VAL_W-1:0] v);
        if (v[VAL_W-1]) begin
            return '0;
        end
        return v[CNT_W-1:0];
    endfunction

    // Active level of one channel for the current counter position.
    function automatic logic active(input logic [CNT_W-1:0] w, input logic [CNT_W-1:0] m,
                                    input logic [CNT_W-1:0] c, input logic u, input logic e);
        logic [CNT_W-1:0] thr;
        thr = m - w;
        if (w == '0) begin
            return 1'b0;
        end
        if (w >= m) begin
            return 1'b1;
        end
        if (e) begin
            return c < w;
        end
        // Center mode compares inclusively on the way up and exclusively on the
        // way down, so the pulse is symmetric about the counter peak.
        return u ? (c >= thr) : (c > thr);
    endfunction

    // Register file, counters, sense sampling and waveform generation.
    always_comb begin
        logic [DIV_W-1:0] lim;
        logic             last_up;
        logic             cyc_end;
        logic             half;
        logic [31:0]      cw;
        logic [2:0]       idx;
        logic [2:0]       vsel;
        logic             hit;
        int               k;

        next_s = s;
        lim = DIV_W'((1 << s.prsc) - 1);
        last_up = s.cnt == CNT_W'(s.mdl - 1'b1);
        cyc_end = 1'b0;
        half = 1'b0;
        cw = '0;
        idx = wb_adr_i[4:2];
        vsel = '0;
        hit = wb_cyc_i && wb_stb_i && !s.ack;
        k = 0;

        // Prescaler producing the PWM clock enable.
        tick = s.div == lim;
        next_s.div = tick ? '0 : DIV_W'(s.div + 1'b1);

        // Period counter.
        if (!s.en) begin
            next_s.cnt = '0;
            next_s.up = 1'b1;
        end else if (tick) begin
            if (s.edge_al) begin
                next_s.cnt = last_up ? '0 : CNT_W'(s.cnt + 1'b1);
                cyc_end = last_up;
            end else if (s.up) begin
                half = last_up;
                next_s.up = !last_up;
                next_s.cnt = last_up ? s.mdl : CNT_W'(s.cnt + 1'b1);
            end else begin
                cyc_end = s.cnt <= CNT_W'(1);
                next_s.up = cyc_end;
                next_s.cnt = cyc_end ? '0 : CNT_W'(s.cnt - 1'b1);
            end
        end

        // Sense pins pass two flip-flops before any use.
        next_s.sync1 = current_sense_pin_i;
        next_s.sync2 = s.sync1;

        // Sense sampling for the two automatic methods.
        if (!s.en) begin
            next_s.samp = '1;
        end else if (s.corr == CORR_DEADTIME) begin
            for (int p = 0; p < NPAIR; p++) begin
                if (dead[p]) begin
                    next_s.samp[p] = s.sync2[p];
                end
            end
        end else if (s.corr == CORR_CYCLE) begin
            if (s.edge_al ? cyc_end : half) begin
                next_s.samp = s.sync2;
            end
        end

        // Odd/even selection, buffered to whole cycles.
        if (!s.en || cyc_end) begin
            case (s.corr)
                CORR_NONE:   next_s.sel = '0;
                CORR_MANUAL: next_s.sel = s.ipol;
                default:     next_s.sel = s.en ? s.samp : '1;
            endcase
        end

        // Waveform per channel; top is even, bottom is odd.
        for (int c = 0; c < NCH; c++) begin
            k = c / 2;
            if (s.indep[k]) begin
                vsel = 3'(c);
            end else begin
                vsel = 3'(2 * k) + 3'(s.sel[k]);
            end
            next_s.gen[c] = s.en && active(clamp(s.val[vsel]), s.mdl, s.cnt, s.up, s.edge_al);
        end

        // Wishbone slave: one ack per request, unmapped words read zero.
        next_s.ack = hit;
        next_s.rdat = '0;
        if (hit) begin
            if (wb_adr_i < ADR_CTRL && wb_adr_i[1:0] == 2'b00) begin
                // Pulse value word.
                cw = 32'(s.val[idx]);
            end else if (wb_adr_i == ADR_CTRL) begin
                // Control word read-back.
                cw[CB_EN] = s.en;
                cw[CB_EDGE] = s.edge_al;
                cw[CB_PRSC +: 2] = s.prsc;
                cw[CB_CORR +: 2] = s.corr;
                cw[CB_INDEP +: NPAIR] = s.indep;
                cw[CB_IPOL +: NPAIR] = s.ipol;
            end else if (wb_adr_i == ADR_MOD) begin
                cw = 32'(s.mdl);
            end else if (wb_adr_i == ADR_DTM) begin
                cw = 32'(s.dtm);
            end else if (wb_adr_i == ADR_STAT) begin
                // Status word shows live counter and correction state.
                cw[SB_CNT +: CNT_W] = s.cnt;
                cw[SB_UP] = s.up;
                cw[SB_SEL +: NPAIR] = s.sel;
                cw[SB_SAMP +: NPAIR] = s.samp;
                cw[SB_DEAD +: NPAIR] = dead;
            end
            if (!wb_we_i) begin
                next_s.rdat = cw;
            end else begin
                // Only the enabled byte lanes replace the current contents.
                cw = merge(cw, wb_dat_i, wb_sel_i);
                if (wb_adr_i < ADR_CTRL && wb_adr_i[1:0] == 2'b00) begin
                    next_s.val[idx] = cw[VAL_W-1:0];
                end else if (wb_adr_i == ADR_CTRL) begin
                    // New mode bits act at once, with no reload buffering.
                    next_s.en = cw[CB_EN];
                    next_s.edge_al = cw[CB_EDGE];
                    next_s.prsc = cw[CB_PRSC +: 2];
                    next_s.corr = corr_t'(cw[CB_CORR +: 2]);
                    next_s.indep = cw[CB_INDEP +: NPAIR];
                    next_s.ipol = cw[CB_IPOL +: NPAIR];
                end else if (wb_adr_i == ADR_MOD) begin
                    next_s.mdl = cw[CNT_W-1:0];
                end else if (wb_adr_i == ADR_DTM) begin
                    next_s.dtm = cw[DT_W-1:0];
                end
            end
        end
    end

    // State register with documented reset values.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.mdl <= MOD_RST;
            s.dtm <= DTM_RST;
            s.up <= 1'b1;
            s.samp <= '1;
            s.sel <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Bus outputs come straight from the state register.
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;

    // One deadtime generator and output path per pair.
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        // A stopped generator runs the pair as independent, so that no bottom
        // pad shows the inverse of an idle top.
        pwm_deadtime_pair #(
            .DT_W (DT_W)
        ) u_dt (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .tick_i   (tick),
            .comp_i   (s.en && !s.indep[p]),
            .top_i    (s.gen[2*p]),
            .bot_i    (s.gen[2*p+1]),
            .dt_len_i (s.dtm),
            .top_o    (pwm_o[2*p]),
            .bot_o    (pwm_o[2*p+1]),
            .dead_o   (dead[p])
        );
    end
endmodule

// [design/pwm_pkg.sv]
// Shared constants and types for the six-channel PWM output stage.
package pwm_pkg;
    localparam int VAL_W  = 16;
    localparam int CNT_W  = 15;
    localparam int DT_W   = 12;
    localparam int NCH    = 6;
    localparam int NPAIR  = 3;
    localparam int DIV_W  = 3;

    // Byte addresses of the register words.
    localparam logic [7:0] ADR_VAL0 = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h18;
    localparam logic [7:0] ADR_MOD  = 8'h1c;
    localparam logic [7:0] ADR_DTM  = 8'h20;
    localparam logic [7:0] ADR_STAT = 8'h24;

    // Control word field positions.
    localparam int CB_EN    = 0;
    localparam int CB_EDGE  = 1;
    localparam int CB_PRSC  = 2;
    localparam int CB_CORR  = 4;
    localparam int CB_INDEP = 6;
    localparam int CB_IPOL  = 9;

    // Status word field positions.
    localparam int SB_CNT  = 0;
    localparam int SB_UP   = 15;
    localparam int SB_SEL  = 16;
    localparam int SB_SAMP = 19;
    localparam int SB_DEAD = 22;

    // Reset values.
    localparam logic [DT_W-1:0]  DTM_RST = 12'h0fff;
    localparam logic [CNT_W-1:0] MOD_RST = 15'h0010;

    // Correction method select encodings.
    typedef enum logic [1:0] {
        CORR_NONE     = 2'b00,
        CORR_MANUAL   = 2'b01,
        CORR_DEADTIME = 2'b10,
        CORR_CYCLE    = 2'b11
    } corr_t;
endpackage

// [tb/gate_drv_model.sv]
// Behavioural gate driver stage with current direction sensing.
`timescale 1ns/1ns
module gate_drv_model (
    input  wire logic                      clk_i,
    input  wire logic [pwm_pkg::NCH-1:0]   pwm_i,
    input  wire logic [pwm_pkg::NPAIR-1:0] neg_i,
    output logic [pwm_pkg::NPAIR-1:0]      sense_o,
    output int                             shorts
);
    import pwm_pkg::*;
    // The sense line is high while the pair current flows negative.
    assign sense_o = neg_i;
    initial shorts = 0;
    // Counts cycles in which both transistors of some pair conduct.
    always @(posedge clk_i) begin
        for (int p = 0; p < NPAIR; p++) begin
            if (pwm_i[2*p] && pwm_i[2*p+1]) shorts <= shorts + 1;
        end
    end
endmodule

// [tb/pwm_monitor.sv]
// Checker for the bus handshake and the pair output safety of the PWM stage.
`timescale 1ns/1ns
module pwm_monitor (
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic [7:0]                wb_adr_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic                      wb_we_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic [pwm_pkg::NPAIR-1:0] current_sense_pin_i,
    input wire logic [pwm_pkg::NCH-1:0]   pwm_o
);
    import pwm_pkg::*;
    logic [11:0]     ctrl;
    logic [DT_W-1:0] dtm;
    logic [2:0]      settle;
    logic [2:0]      ov;
    logic            wr;
    // A write is taken when the request stands with ack low.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    // Overlap of top and bottom, counted only for complementary pairs.
    assign ov = ~ctrl[8:6] & {pwm_o[4] & pwm_o[5], pwm_o[2] & pwm_o[3], pwm_o[0] & pwm_o[1]};
    // Shadow of control and deadtime words, with cycles since the last write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= 12'h000;
            dtm <= DTM_RST;
            settle <= 3'h0;
        end else if (wr) begin
            settle <= 3'h0;
            if (wb_adr_i == ADR_CTRL) ctrl <= wb_dat_i[11:0];
            if (wb_adr_i == ADR_DTM) dtm <= wb_dat_i[DT_W-1:0];
        end else if (settle != 3'h7) begin
            settle <= settle + 3'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers come one cycle after the request and last one cycle.
    property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_rst_out; disable iff (1'b0) rst_i |=> pwm_o == 6'h00 && !wb_ack_o; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
    // Pair outputs are judged once the last register write has settled.
    property p_no_overlap; settle == 3'h7 |-> ov == 3'h0; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("top and bottom both on");
    property p_disabled; settle == 3'h7 && !ctrl[0] |-> pwm_o == 6'h00; endproperty
    a_disabled: assert property (p_disabled) else $error("output on while disabled");
    property p_dead_gap; settle == 3'h7 && !ctrl[6] && dtm != 0 && $fell(pwm_o[0]) |=> !pwm_o[1]; endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("bottom on without deadtime");
endmodule
bind pwm_pair_deadtime_correction pwm_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .current_sense_pin_i(current_sense_pin_i), .pwm_o(pwm_o));

// [tb/test_pwm_pair_deadtime_correction.sv]
// Self-checking bench for the PWM output stage.
`timescale 1ns/1ns
module test_pwm_pair_deadtime_correction;
    import pwm_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [7:0]       wb_adr_i = 8'h00;
    logic [31:0]      wb_dat_i = 32'h0000_0000;
    logic [3:0]       wb_sel_i = 4'hf;
    logic             wb_we_i = 1'b0;
    logic             wb_cyc_i = 1'b0;
    logic             wb_stb_i = 1'b0;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    logic [NPAIR-1:0] sense;
    logic [NPAIR-1:0] neg = 3'h0;
    logic [NCH-1:0]   pwm_o;
    logic [31:0]      q;
    int               shorts;
    int               n_errors = 0;
    int               num_checks = 0;
    logic [15:0]      vals [6] = '{16'h0002, 16'hffff, 16'h0004, 16'h7fff, 16'h0000, 16'h0001};
    int               tbl [6] = '{20, 0, 40, 40, 0, 10};
    always #20 clk_i = ~clk_i;
    pwm_pair_deadtime_correction uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .current_sense_pin_i(sense), .pwm_o(pwm_o));
    gate_drv_model drv (.clk_i(clk_i), .pwm_i(pwm_o), .neg_i(neg), .sense_o(sense), .shorts(shorts));
    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle; read data is taken at the ack edge.
    // A missing answer is left to the watchdog.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Counts the cycles in which one output is high.
    task automatic cnt(input int ch, input int n);
        q = 32'h0000_0000;
        repeat (n) begin
            @(posedge clk_i);
            if (pwm_o[ch] === 1'b1) q++;
        end
    endtask
    function automatic logic [31:0] ctl(input logic edg, input logic [1:0] ps, input logic [1:0] m,
                                        input logic [2:0] ind, input logic [2:0] ip);
        return {20'h0_0000, ip, ind, m, ps, edg, 1'b1};
    endfunction
    // Complementary pairs over ten periods of 8 with a deadtime of 2.
    task automatic comp(input logic [2:0] odd);
        int s;
        repeat (64) @(posedge clk_i);
        s = shorts;
        for (int p = 0; p < NPAIR; p++) begin
            cnt(2*p, 80);
            check(q, odd[p] ? 40 : 20);
            cnt(2*p+1, 80);
            check(q, odd[p] ? 0 : 20);
        end
        check(shorts - s, 0);
    endtask
    initial begin
        #400000;
        n_errors++;
        results;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, ADR_CTRL, 0);
        check(q, 32'h0000_0000);
        wb(0, ADR_MOD, 0);
        check(q, 32'h0000_0010);
        wb(0, ADR_DTM, 0);
        check(q, 32'h0000_0fff);
        wb(0, ADR_STAT, 0);
        check(q, 32'h0038_8000);
        wb(1, ADR_VAL0, 32'h0001_8001);
        wb(0, ADR_VAL0, 0);
        check(q, 32'h0000_8001);
        wb(1, 8'h30, 32'hffff_ffff);
        wb(0, 8'h30, 0);
        check(q, 32'h0000_0000);
        // Independent channels: edge /1, center /1, edge /2.
        wb(1, ADR_MOD, 4);
        for (int i = 0; i < NCH; i++) wb(1, 8'(4*i), {16'h0000, vals[i]});
        for (int c = 0; c < 3; c++) begin
            wb(1, ADR_CTRL, ctl(c != 1, {1'b0, c == 2}, CORR_NONE, 3'h7, 3'h0));
            repeat (64) @(posedge clk_i);
            for (int i = 0; i < NCH; i++) begin
                cnt(i, 80);
                check(q, 2*tbl[i]);
            end
        end
        wb(1, ADR_MOD, 8);
        wb(1, ADR_DTM, 2);
        for (int p = 0; p < NPAIR; p++) begin
            wb(1, 8'(8*p), 4);
            wb(1, 8'(8*p+4), 6);
        end
        wb(1, ADR_CTRL, ctl(1, 0, CORR_NONE, 0, 3'h5));
        comp(3'h0);
        wb(1, ADR_CTRL, ctl(1, 0, CORR_MANUAL, 0, 3'h5));
        comp(3'h5);
        neg <= 3'h2;
        wb(1, ADR_CTRL, ctl(1, 0, CORR_CYCLE, 0, 3'h0));
        comp(3'h2);
        neg <= 3'h5;
        wb(1, ADR_CTRL, ctl(1, 0, CORR_DEADTIME, 0, 3'h0));
        comp(3'h5);
        // Center-aligned pairs over ten periods of 8, values one apart for half the deadtime.
        wb(1, ADR_CTRL, 0);
        wb(1, ADR_MOD, 4);
        for (int p = 0; p < NPAIR; p++) begin
            wb(1, 8'(8*p), 2);
            wb(1, 8'(8*p+4), 3);
        end
        wb(1, ADR_CTRL, ctl(0, 0, CORR_MANUAL, 0, 3'h5));
        comp(3'h5);
        results;
    end
endmodule
